//--- hdl/stage_params.svh
// Purpose: constants for the protection stage control block
// Assumes: 200 MHz clock, times in the units named
// Notes: timing counts are derived from times and the clock rate
//
// Functional notes
// RULE1 - Four setting groups, exactly one active
// RULE2 - No input active: use default group
// RULE3 - Keep-last holds group when control lost
// RULE4 - Conflicts resolved by ascending or descending priority
// RULE5 - Global override applies without local control
// RULE6 - Status is idle, blocked, start or trip
// RULE7 - Start and trip counters, cleared on reboot
// RULE8 - Test flag allows forced start/trip, half second
// RULE9 - Test flag clears five minutes after panel activity
// RULE10 - Test flag also permits output forcing
// RULE11 - Start on fault, trip after delay only
// RULE12 - Fault comparison uses hysteresis
// RULE13 - Blocked stage never enters start
// RULE14 - Block freezes the delay count
// RULE15 - Block has no effect once tripped
// RULE16 - Dependent mode: bigger quantity, faster trip
// RULE17 - Definite timer resets without trip on drop
// RULE18 - Zero delay rejected unless allowed
// RULE19 - Cleared fault stops timing within 50 ms
// RULE20 - Release delay then drop outputs unless latched
// RULE21 - Release delay below 95 ms
// RULE22 - Keep last eight fault records
// RULE23 - Currents below squelch forced to zero
// RULE24 - Full record store overwrites the oldest
`ifndef STAGE_PARAMS_SVH
`define STAGE_PARAMS_SVH
`define CLK_MHZ 200
`define FORCE_TIME_MS 500
`define FORCE_CYCLES (`FORCE_TIME_MS * 1000 * `CLK_MHZ)
`define TESTFLAG_TIME_S 300
`define TESTFLAG_CYCLES (64'd`TESTFLAG_TIME_S * 64'd1000000 * 64'd`CLK_MHZ)
`define RELEASE_TIME_MS 80
`define RELEASE_CYCLES (`RELEASE_TIME_MS * 1000 * `CLK_MHZ)
`define SQUELCH_NUM 5
`define SQUELCH_DEN 1000
`define NUM_GROUPS 4
`define NUM_RECORDS 8
`define ADDR_CTRL 4'h0
`define ADDR_DELAY 4'h1
`define ADDR_START_LVL 4'h2
`define ADDR_HYST 4'h3
`define ADDR_GROUPCFG 4'h4
`define ADDR_STATUS 4'h5
`define ADDR_COUNTS 4'h6
`define ADDR_REC_SEL 4'h7
`define ADDR_REC_VAL 4'h8
`define ADDR_REC_TIME 4'h9
`define ADDR_REC_INFO 4'hA
`define ADDR_RATED 4'hB
`define CTRL_DEP_BIT 0
`define CTRL_LATCH_BIT 1
`define CTRL_ZERO_OK_BIT 2
`define CTRL_TEST_BIT 3
`define CTRL_FSTART_BIT 4
`define CTRL_FTRIP_BIT 5
`define CTRL_UNLATCH_BIT 6
`define GCFG_DEF_LSB 0
`define GCFG_KEEP_BIT 2
`define GCFG_DESC_BIT 3
`define GCFG_OVR_EN_BIT 4
`define GCFG_OVR_LSB 5
`define GCFG_LOCAL_BIT 7
`define RST_DELAY 32'h0000_C350
`define RST_START_LVL 32'h0000_0100
`endif

//--- hdl/stage_pkg.sv
// Purpose: types for the protection stage control block
// Assumes: stage_params.svh holds the numbers
// Notes: none
package stage_pkg;
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_BLOCKED = 2'b01,
      ST_START = 2'b10,
      ST_TRIP = 2'b11
   } stage_state_t;

   typedef struct packed {
      logic [3:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } reg_req_t;

   typedef struct packed {
      logic start;
      logic trip;
      logic force_permit;
      logic [1:0] group;
   } stage_out_t;

   typedef struct packed {
      logic [31:0] time_stamp;
      logic [15:0] value;
      logic [31:0] elapsed;
      logic [1:0] group;
   } fault_rec_t;
endpackage : stage_pkg

//--- hdl/protection_stage_control.sv
// Purpose: common stage logic: group select, state, timing, counters, records
// Assumes: measured value and inputs synchronous to clock, one sample per cycle
// Notes: dependent mode uses a simple time-over-quantity accumulator
`timescale 1ns/100ps
`include "stage_params.svh"
module protection_stage_control #(
   parameter int VW = 16,
   parameter longint FORCE_CYC = `FORCE_CYCLES,
   parameter longint TESTFLAG_CYC = `TESTFLAG_CYCLES,
   parameter longint RELEASE_CYC = `RELEASE_CYCLES
) (
   // Clock and reset
   input wire logic clock,
   input wire logic rst_n,
   input wire logic clk_en,
   // Register port
   input wire stage_pkg::reg_req_t req,
   output logic [31:0] rdata,
   // Measurement and control
   input wire logic [VW-1:0] measured,
   input wire logic [3:0] group_input_assignment,
   input wire logic block_in,
   input wire logic panel_activity,
   // Results
   output stage_pkg::stage_out_t result,
   output logic [1:0] stage_state
);
   import stage_pkg::*;

   typedef struct packed {
      logic [31:0] ctrl;
      logic [31:0] delay;
      logic [31:0] start_lvl;
      logic [31:0] hyst;
      logic [31:0] gcfg;
      logic [31:0] rated;
      logic [2:0] rec_sel;
      stage_state_t st;
      logic fault;
      logic [1:0] group;
      logic [1:0] last_group;
      logic [63:0] acc;
      logic [31:0] elapsed;
      logic [31:0] rel_cnt;
      logic releasing;
      logic [63:0] test_cnt;
      logic [31:0] force_cnt;
      logic forcing;
      logic force_trip;
      logic [31:0] start_cnt;
      logic [31:0] trip_cnt;
      logic [31:0] tstamp;
      logic [2:0] wr_ptr;
      logic [3:0] rec_count;
      logic start_o;
      logic trip_o;
      logic [31:0] rdata;
   } state_t;

   state_t s_r;
   state_t s_nxt;
   fault_rec_t recs_r [`NUM_RECORDS];
   logic rec_we;
   fault_rec_t rec_new;
   logic rst_sync1_r;
   logic rst_sync2_r;

   // Reset released through two flops so release is clean to the clock
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         rst_sync1_r <= 1'b0;
         rst_sync2_r <= 1'b0;
      end else begin
         rst_sync1_r <= 1'b1;
         rst_sync2_r <= rst_sync1_r;
      end
   end

   // Lowest or highest numbered active input
   function automatic logic [1:0] pick_group(input logic [3:0] act, input logic desc);
      logic [1:0] g;
      g = 2'h0;
      if (desc) begin
         for (int i = 0; i < `NUM_GROUPS; i++) begin
            if (act[i]) g = 2'(i);
         end
      end else begin
         for (int i = `NUM_GROUPS - 1; i >= 0; i--) begin
            if (act[i]) g = 2'(i);
         end
      end
      return g;
   endfunction : pick_group

   logic [VW-1:0] meas_q;
   logic [31:0] squelch_lvl;
   logic fault_now;
   logic [31:0] eff_delay;
   logic delay_ok;
   logic [31:0] drop_lvl;

   always_comb begin
      s_nxt = s_r;
      rec_we = 1'b0;
      rec_new = '0;
      s_nxt.tstamp = s_r.tstamp + 32'h1;
      // Squelch limit as fraction of rated current
      squelch_lvl = 32'((64'(s_r.rated) * `SQUELCH_NUM) / `SQUELCH_DEN);
      meas_q = (32'(measured) < squelch_lvl) ? '0 : measured; // RULE23
      // Hysteresis: drop only below start level minus dead band
      // A band wider than the level would wrap; a zero reading still ends the fault
      drop_lvl = (s_r.hyst < s_r.start_lvl) ? s_r.start_lvl - s_r.hyst : 32'h1;
      if (s_r.fault) begin
         fault_now = 32'(meas_q) >= drop_lvl; // RULE12
      end else begin
         fault_now = 32'(meas_q) >= s_r.start_lvl;
      end
      s_nxt.fault = fault_now;
      // Zero delay only with explicit permission; otherwise one tick
      delay_ok = (s_r.delay != 32'h0) || s_r.ctrl[`CTRL_ZERO_OK_BIT];
      eff_delay = delay_ok ? s_r.delay : 32'h1; // RULE18

      // Setting group selection
      if (s_r.gcfg[`GCFG_OVR_EN_BIT] && !s_r.gcfg[`GCFG_LOCAL_BIT]) begin
         s_nxt.group = s_r.gcfg[`GCFG_OVR_LSB +: 2]; // RULE5
      end else if (group_input_assignment != 4'h0) begin
         s_nxt.group = pick_group(group_input_assignment, s_r.gcfg[`GCFG_DESC_BIT]); // RULE4
      end else if (s_r.gcfg[`GCFG_KEEP_BIT]) begin
         s_nxt.group = s_r.last_group; // RULE3
      end else begin
         s_nxt.group = s_r.gcfg[`GCFG_DEF_LSB +: 2]; // RULE2
      end
      s_nxt.last_group = s_nxt.group; // RULE1

      // Test flag auto-release after panel idle
      if (s_r.ctrl[`CTRL_TEST_BIT]) begin
         if (panel_activity) begin
            s_nxt.test_cnt = '0;
         end else if (s_r.test_cnt >= 64'(TESTFLAG_CYC) - 64'h1) begin
            s_nxt.ctrl[`CTRL_TEST_BIT] = 1'b0; // RULE9
            s_nxt.test_cnt = '0;
         end else begin
            s_nxt.test_cnt = s_r.test_cnt + 64'h1;
         end
      end else begin
         s_nxt.test_cnt = '0;
      end

      // Forced start or trip lasts a fixed time
      if (s_r.forcing) begin
         if (s_r.force_cnt >= 32'(FORCE_CYC) - 32'h1) begin
            s_nxt.forcing = 1'b0; // RULE8
         end else begin
            s_nxt.force_cnt = s_r.force_cnt + 32'h1;
         end
      end

      // Stage state machine
      case (s_r.st)
         ST_IDLE: begin
            s_nxt.acc = '0;
            s_nxt.elapsed = '0;
            if (fault_now && block_in) begin
               s_nxt.st = ST_BLOCKED; // RULE13
            end else if (fault_now) begin
               s_nxt.st = ST_START; // RULE11
               s_nxt.start_cnt = s_r.start_cnt + 32'h1; // RULE7
            end
         end
         ST_BLOCKED: begin
            if (!fault_now) begin
               s_nxt.st = ST_IDLE; // RULE17
               s_nxt.acc = '0;
               s_nxt.elapsed = '0;
            end else if (!block_in) begin
               s_nxt.st = ST_START; // RULE14
               if (s_r.acc == 64'h0) s_nxt.start_cnt = s_r.start_cnt + 32'h1;
            end
         end
         ST_START: begin
            if (!fault_now) begin
               s_nxt.st = ST_IDLE; // RULE19
               s_nxt.acc = '0;
               s_nxt.elapsed = '0;
            end else if (block_in) begin
               s_nxt.st = ST_BLOCKED; // RULE14
            end else begin
               s_nxt.elapsed = s_r.elapsed + 32'h1;
               if (s_r.ctrl[`CTRL_DEP_BIT]) begin
                  s_nxt.acc = s_r.acc + 64'(meas_q); // RULE16
                  if (s_nxt.acc >= 64'(eff_delay) * 64'(s_r.start_lvl)) begin
                     s_nxt.st = ST_TRIP;
                  end
               end else begin
                  s_nxt.acc = s_r.acc + 64'h1; // RULE17
                  if (s_nxt.acc >= 64'(eff_delay)) s_nxt.st = ST_TRIP;
               end
               if (s_nxt.st == ST_TRIP) begin
                  s_nxt.trip_cnt = s_r.trip_cnt + 32'h1; // RULE7
                  rec_we = 1'b1; // RULE22
                  rec_new.time_stamp = s_r.tstamp;
                  rec_new.value = 16'(meas_q);
                  rec_new.elapsed = s_nxt.elapsed;
                  rec_new.group = s_r.group;
               end
            end
         end
         ST_TRIP: begin
            // Block ignored here
            if (!fault_now) begin // RULE15
               s_nxt.st = ST_IDLE; // RULE6
               s_nxt.acc = '0;
               s_nxt.elapsed = '0;
            end
         end
         default: s_nxt.st = ST_IDLE;
      endcase

      // Release delay before outputs drop
      if (s_nxt.st == ST_START || s_nxt.st == ST_TRIP) begin
         s_nxt.start_o = 1'b1;
         s_nxt.releasing = 1'b0;
         s_nxt.rel_cnt = '0;
         if (s_nxt.st == ST_TRIP) s_nxt.trip_o = 1'b1;
      end else if (s_r.start_o || s_r.trip_o) begin
         if (s_r.ctrl[`CTRL_LATCH_BIT] && s_r.trip_o) begin
            s_nxt.start_o = 1'b0; // RULE20
         end else if (s_r.rel_cnt >= 32'(RELEASE_CYC) - 32'h1) begin
            s_nxt.start_o = 1'b0; // RULE21
            s_nxt.trip_o = 1'b0;
            s_nxt.rel_cnt = '0;
         end else begin
            s_nxt.rel_cnt = s_r.rel_cnt + 32'h1;
         end
      end
      if (s_r.forcing) begin
         s_nxt.start_o = 1'b1;
         s_nxt.trip_o = s_r.force_trip;
         // Forced pulse over: outputs return to what the stage itself shows
         if (!s_nxt.forcing) begin
            s_nxt.start_o = (s_nxt.st == ST_START) || (s_nxt.st == ST_TRIP);
            s_nxt.trip_o = (s_nxt.st == ST_TRIP);
         end
      end

      // Register writes and reads
      s_nxt.rdata = '0;
      if (req.wr) begin
         case (req.addr)
            `ADDR_CTRL: begin
               s_nxt.ctrl = {28'h0, req.wdata[3:0]};
               if (req.wdata[`CTRL_TEST_BIT]) s_nxt.test_cnt = '0;
               if (s_r.ctrl[`CTRL_TEST_BIT] && !s_r.forcing &&
                   (req.wdata[`CTRL_FSTART_BIT] || req.wdata[`CTRL_FTRIP_BIT])) begin
                  s_nxt.forcing = 1'b1; // RULE8
                  s_nxt.force_cnt = '0;
                  s_nxt.force_trip = req.wdata[`CTRL_FTRIP_BIT];
               end
               if (req.wdata[`CTRL_UNLATCH_BIT] && s_nxt.st != ST_TRIP) begin
                  s_nxt.trip_o = 1'b0;
               end
            end
            `ADDR_DELAY: s_nxt.delay = req.wdata;
            `ADDR_START_LVL: s_nxt.start_lvl = req.wdata;
            `ADDR_HYST: s_nxt.hyst = req.wdata;
            `ADDR_GROUPCFG: s_nxt.gcfg = {24'h0, req.wdata[7:0]};
            `ADDR_REC_SEL: s_nxt.rec_sel = req.wdata[2:0];
            `ADDR_RATED: s_nxt.rated = req.wdata;
            default: ;
         endcase
      end
      if (req.rd) begin
         case (req.addr)
            `ADDR_CTRL: s_nxt.rdata = s_r.ctrl;
            `ADDR_DELAY: s_nxt.rdata = s_r.delay;
            `ADDR_START_LVL: s_nxt.rdata = s_r.start_lvl;
            `ADDR_HYST: s_nxt.rdata = s_r.hyst;
            `ADDR_GROUPCFG: s_nxt.rdata = s_r.gcfg;
            `ADDR_STATUS: s_nxt.rdata = {22'h0, !delay_ok, s_r.forcing, s_r.rec_count,
                                          s_r.group, s_r.st};
            `ADDR_COUNTS: s_nxt.rdata = {s_r.trip_cnt[15:0], s_r.start_cnt[15:0]};
            `ADDR_REC_SEL: s_nxt.rdata = {29'h0, s_r.rec_sel};
            `ADDR_REC_VAL: s_nxt.rdata = {14'h0, recs_r[s_r.rec_sel].group,
                                          recs_r[s_r.rec_sel].value};
            `ADDR_REC_TIME: s_nxt.rdata = recs_r[s_r.rec_sel].time_stamp;
            `ADDR_REC_INFO: s_nxt.rdata = recs_r[s_r.rec_sel].elapsed;
            `ADDR_RATED: s_nxt.rdata = s_r.rated;
            default: s_nxt.rdata = '0;
         endcase
      end
      if (rec_we) begin
         s_nxt.wr_ptr = s_r.wr_ptr + 3'h1; // RULE24
         if (s_r.rec_count != 4'(`NUM_RECORDS)) s_nxt.rec_count = s_r.rec_count + 4'h1;
      end
   end

   always_ff @(posedge clock or negedge rst_sync2_r) begin
      if (!rst_sync2_r) begin
         s_r <= '0;
         s_r.delay <= `RST_DELAY;
         s_r.start_lvl <= `RST_START_LVL;
         s_r.st <= ST_IDLE;
      end else if (clk_en) begin
         s_r <= s_nxt;
      end
   end

   // Volatile record store, not reset; ring of eight
   always_ff @(posedge clock) begin
      if (clk_en && rec_we) recs_r[s_r.wr_ptr] <= rec_new; // RULE22
   end

   always_comb begin
      rdata = s_r.rdata;
      result.start = s_r.start_o;
      result.trip = s_r.trip_o;
      result.force_permit = s_r.ctrl[`CTRL_TEST_BIT]; // RULE10
      result.group = s_r.group;
      stage_state = s_r.st;
   end

   a_block_no_start: assert property (@(posedge clock) disable iff (!rst_sync2_r) // RULE13
      (clk_en && s_r.st == ST_IDLE && block_in) |=> s_r.st != ST_START)
      else $error("blocked stage entered start");
   a_trip_holds_block: assert property (@(posedge clock) disable iff (!rst_sync2_r) // RULE15
      (clk_en && s_r.st == ST_TRIP && s_r.fault && fault_now) |=> s_r.st == ST_TRIP)
      else $error("trip left while fault present");
   a_block_freezes: assert property (@(posedge clock) disable iff (!rst_sync2_r) // RULE14
      (clk_en && s_r.st == ST_BLOCKED && fault_now) |=> $stable(s_r.acc))
      else $error("delay count moved while blocked");
   a_trip_counter: assert property (@(posedge clock) disable iff (!rst_sync2_r) // RULE7
      (clk_en && s_r.st == ST_START && s_nxt.st == ST_TRIP)
      |=> s_r.trip_cnt == $past(s_r.trip_cnt) + 32'h1)
      else $error("trip counter missed");
   a_group_default: assert property (@(posedge clock) disable iff (!rst_sync2_r) // RULE2
      (clk_en && group_input_assignment == 4'h0 && !s_r.gcfg[`GCFG_KEEP_BIT]
       && !s_r.gcfg[`GCFG_OVR_EN_BIT]) |=> s_r.group == $past(s_r.gcfg[`GCFG_DEF_LSB +: 2]))
      else $error("default group not used");
   a_clear_stops: assert property (@(posedge clock) disable iff (!rst_sync2_r) // RULE19
      (clk_en && s_r.st == ST_START && !fault_now) |=> s_r.st == ST_IDLE)
      else $error("timing continued after fault cleared");
   a_start_output: assert property (@(posedge clock) disable iff (!rst_sync2_r) // RULE11
      (clk_en && s_r.st == ST_IDLE && fault_now && !block_in) |=> result.start)
      else $error("start not asserted on fault");
   a_test_needed: assert property (@(posedge clock) disable iff (!rst_sync2_r) // RULE8
      (clk_en && !s_r.forcing && !s_r.ctrl[`CTRL_TEST_BIT]) |=> !s_r.forcing)
      else $error("forcing without test flag");

   // Group choice checks
   a_override_group: assert property (@(posedge clock) disable iff (!rst_sync2_r) // RULE5
      (clk_en && s_r.gcfg[`GCFG_OVR_EN_BIT] && !s_r.gcfg[`GCFG_LOCAL_BIT])
      |=> s_r.group == $past(s_r.gcfg[`GCFG_OVR_LSB +: 2]))
      else $error("override group not used");
   a_asc_lowest: assert property (@(posedge clock) disable iff (!rst_sync2_r) // RULE4
      (clk_en && !(s_r.gcfg[`GCFG_OVR_EN_BIT] && !s_r.gcfg[`GCFG_LOCAL_BIT])
       && group_input_assignment[0] && !s_r.gcfg[`GCFG_DESC_BIT]) |=> s_r.group == 2'h0)
      else $error("ascending order missed lowest group");
   a_desc_highest: assert property (@(posedge clock) disable iff (!rst_sync2_r) // RULE4
      (clk_en && !(s_r.gcfg[`GCFG_OVR_EN_BIT] && !s_r.gcfg[`GCFG_LOCAL_BIT])
       && group_input_assignment[3] && s_r.gcfg[`GCFG_DESC_BIT]) |=> s_r.group == 2'h3)
      else $error("descending order missed highest group");
   a_keep_last: assert property (@(posedge clock) disable iff (!rst_sync2_r) // RULE3
      (clk_en && !(s_r.gcfg[`GCFG_OVR_EN_BIT] && !s_r.gcfg[`GCFG_LOCAL_BIT])
       && group_input_assignment == 4'h0 && s_r.gcfg[`GCFG_KEEP_BIT]) |=> $stable(s_r.group))
      else $error("group changed with control lost");

   // Stage, test flag and record checks
   a_fault_needs_level: assert property (@(posedge clock) disable iff (!rst_sync2_r) // RULE12
      (clk_en && !s_r.fault && 32'(meas_q) < s_r.start_lvl) |=> !s_r.fault)
      else $error("fault declared below start level");
   a_trip_after_start: assert property (@(posedge clock) disable iff (!rst_sync2_r) // RULE11
      (clk_en && s_r.st != ST_START && s_r.st != ST_TRIP) |=> s_r.st != ST_TRIP)
      else $error("trip reached without start");
   a_panel_keeps_test: assert property (@(posedge clock) disable iff (!rst_sync2_r) // RULE9
      (clk_en && s_r.ctrl[`CTRL_TEST_BIT] && panel_activity && !req.wr)
      |=> s_r.ctrl[`CTRL_TEST_BIT])
      else $error("test flag dropped during panel activity");
   a_permit_needs_flag: assert property (@(posedge clock) disable iff (!rst_sync2_r) // RULE10
      (clk_en && !s_r.ctrl[`CTRL_TEST_BIT] && !req.wr) |=> !result.force_permit)
      else $error("output forcing permitted without test flag");
   a_rec_ring: assert property (@(posedge clock) disable iff (!rst_sync2_r) // RULE24
      (clk_en && rec_we) |=> s_r.wr_ptr == $past(s_r.wr_ptr) + 3'h1)
      else $error("record slot pointer did not advance");
endmodule : protection_stage_control

//--- verif/stage_front_end.sv
// Purpose: front end model: measured value, group inputs and block signal
// Assumes: one new sample per clock, no pull on any line
// Notes: values move just after the rising edge, as a sampled front end would
`timescale 1ns/100ps
module stage_front_end (
   // Clock
   input wire logic clock,
   // Commands from the bench
   input wire logic [15:0] level,
   input wire logic [3:0] grp,
   input wire logic blk,
   // To the stage
   output logic [15:0] measured = 16'h0000,
   output logic [3:0] group_input_assignment = 4'h0,
   output logic block_in = 1'b0
);
   // One register stage: the stage never sees a value in the cycle it was asked for
   always_ff @(posedge clock) begin
      measured <= level;
      group_input_assignment <= grp;
      block_in <= blk;
   end
endmodule : stage_front_end

//--- verif/protection_stage_control_test.sv
// Purpose: self-checking bench for protection_stage_control
// Assumes: short force, test flag and release counts
// Notes: expected values come from bench constants and the exp_group function
`timescale 1ns/100ps
`include "stage_params.svh"
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin errors++; \
   $display("BAD %0t %h %h", $time, (a), (b)); end end
module protection_stage_control_test;
   import stage_pkg::*;
   localparam int REL = 10;
   logic clock = 1'b0;
   logic rst_n = 1'b0;
   reg_req_t req = '0;
   logic [31:0] rdata, d;
   logic [31:0] lfsr = 32'h97FAAF04;
   logic [15:0] level = 16'h0000;
   logic [15:0] measured;
   logic [3:0] grp = 4'h0;
   logic [3:0] gia;
   logic [3:0] g;
   logic blk = 1'b0;
   logic block_in;
   logic panel = 1'b0;
   logic dsc;
   stage_out_t result;
   logic [1:0] stage_state;
   int errors = 0;
   int n_tests = 0;
   int t, t2, i;

   stage_front_end stage_front_end_inst (.clock(clock), .level(level), .grp(grp), .blk(blk),
      .measured(measured), .group_input_assignment(gia), .block_in(block_in));
   protection_stage_control #(.FORCE_CYC(20), .TESTFLAG_CYC(50), .RELEASE_CYC(REL))
      protection_stage_control_inst (.clock(clock), .rst_n(rst_n), .clk_en(1'b1), .req(req),
      .rdata(rdata), .measured(measured), .group_input_assignment(gia),
      .block_in(block_in), .panel_activity(panel), .result(result),
      .stage_state(stage_state));

   initial begin
      forever #2.5 clock = ~clock;
   end

   function automatic logic [31:0] next_rand(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : next_rand

   function automatic logic [1:0] exp_group(input logic [3:0] in, input logic desc,
      input logic [1:0] def);
      if (in == 4'h0) return def;
      for (int k = 0; k < 4; k++) begin
         if (in[desc ? 3 - k : k]) return desc ? 2'(3 - k) : 2'(k);
      end
      return def;
   endfunction : exp_group

   function automatic logic [1:0] obs(input int sel);
      case (sel)
         0: return stage_state;
         1: return result.group;
         2: return {1'b0, result.trip};
         3: return {1'b0, result.start};
         default: return {1'b0, result.force_permit};
      endcase
   endfunction : obs

   task automatic final_report;
      if (errors == 0 && n_tests > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : final_report

   task automatic wr(input logic [3:0] a, input logic [31:0] v);
      @(posedge clock);
      req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
      @(posedge clock);
      req <= '0;
   endtask : wr

   task automatic rd(input logic [3:0] a, output logic [31:0] v);
      @(posedge clock);
      req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
      @(posedge clock);
      req <= '0;
      @(posedge clock);
      v = rdata;
   endtask : rd

   // Bounded wait: a hang ends the run instead of stalling it
   task automatic wait_for(input int sel, input logic [1:0] v, input int bound);
      for (int k = 0; k < bound && obs(sel) !== v; k++) @(posedge clock);
      `CHK(obs(sel), v)
      if (obs(sel) !== v) final_report();
   endtask : wait_for

   task automatic hold(input int sel, input logic [1:0] v, input int n);
      logic ok;
      ok = 1'b1;
      repeat (n) begin
         @(posedge clock);
         if (obs(sel) !== v) ok = 1'b0;
      end
      `CHK(ok, 1'b1)
   endtask : hold

   task automatic time_trip(input logic [15:0] m, output int n);
      level <= m;
      for (n = 0; n < 300 && result.trip !== 1'b1; n++) @(posedge clock);
   endtask : time_trip

   task automatic clear_fault;
      level <= 16'h0000;
      wait_for(2, 2'd0, REL + 12);
      wait_for(3, 2'd0, REL + 12);
      wait_for(0, ST_IDLE, 4);
   endtask : clear_fault

   initial begin
      repeat (100000) @(posedge clock);
      errors++;
      final_report();
   end

   initial begin
      repeat (6) @(posedge clock);
      rst_n <= 1'b1;
      repeat (4) @(posedge clock);
      rd(`ADDR_DELAY, d);
      `CHK(d, `RST_DELAY)
      rd(4'hF, d);
      `CHK(d, 32'h0)
      // Group choice, with and without local control, random and hand-picked inputs
      wr(`ADDR_GROUPCFG, 32'h82);
      wait_for(1, 2'd2, 8);
      for (i = 0; i < 12; i++) begin
         lfsr = next_rand(lfsr);
         g = (i < 2) ? 4'h6 : lfsr[11:8];
         dsc = (i < 2) ? i[0] : lfsr[3];
         grp <= g;
         wr(`ADDR_GROUPCFG, {24'h0, 4'h8, dsc, 1'b0, lfsr[1:0]});
         wait_for(1, exp_group(g, dsc, lfsr[1:0]), 8);
      end
      grp <= 4'h8;
      wr(`ADDR_GROUPCFG, 32'h84);
      wait_for(1, 2'd3, 8);
      grp <= 4'h0;
      hold(1, 2'd3, 10);
      wr(`ADDR_GROUPCFG, 32'h80);
      wait_for(1, 2'd0, 8);
      wr(`ADDR_GROUPCFG, 32'h30);
      wait_for(1, 2'd1, 8);
      grp <= 4'h8;
      wr(`ADDR_GROUPCFG, 32'hB0);
      wait_for(1, 2'd3, 8);
      grp <= 4'h0;
      wr(`ADDR_GROUPCFG, 32'h80);
      // Definite delay, release and early clearing
      wr(`ADDR_DELAY, 32'd30);
      wr(`ADDR_HYST, 32'h20);
      time_trip(16'h0200, t);
      `CHK(t >= 30 && t <= 36, 1'b1)
      wait_for(0, ST_TRIP, 3);
      level <= 16'h0000;
      hold(2, 2'd1, 5);
      wait_for(2, 2'd0, REL + 8);
      clear_fault();
      level <= 16'h0300;
      wait_for(0, ST_START, 6);
      repeat (10) @(posedge clock);
      level <= 16'h0000;
      wait_for(0, ST_IDLE, 8);
      hold(2, 2'd0, 40);
      clear_fault();
      // Hysteresis band around the start level
      wr(`ADDR_DELAY, 32'd1000);
      level <= 16'h0200;
      wait_for(0, ST_START, 6);
      level <= 16'h00F0;
      hold(0, ST_START, 12);
      level <= 16'h00D0;
      wait_for(0, ST_IDLE, 8);
      clear_fault();
      level <= 16'h00F0;
      hold(0, ST_IDLE, 12);
      level <= 16'h0000;
      rd(`ADDR_COUNTS, d);
      `CHK(d, {16'd1, 16'd3})
      // Blocking before start, during the delay and after trip
      wr(`ADDR_DELAY, 32'd30);
      blk <= 1'b1;
      level <= 16'h0200;
      wait_for(0, ST_BLOCKED, 6);
      hold(3, 2'd0, 10);
      blk <= 1'b0;
      wait_for(0, ST_START, 6);
      repeat (15) @(posedge clock);
      blk <= 1'b1;
      hold(2, 2'd0, 60);
      blk <= 1'b0;
      time_trip(16'h0200, t);
      `CHK(t >= 8 && t <= 22, 1'b1)
      blk <= 1'b1;
      hold(2, 2'd1, 10);
      blk <= 1'b0;
      clear_fault();
      // Dependent delay: faster for larger values, restart after a drop
      wr(`ADDR_CTRL, 32'h1);
      wr(`ADDR_DELAY, 32'd20);
      time_trip(16'h1000, t);
      clear_fault();
      time_trip(16'h0200, t2);
      `CHK(t < t2 && t2 >= 10 && t2 <= 16, 1'b1)
      clear_fault();
      level <= 16'h0200;
      repeat (6) @(posedge clock);
      level <= 16'h0080;
      repeat (4) @(posedge clock);
      time_trip(16'h0200, t);
      `CHK(t >= 10, 1'b1)
      clear_fault();
      // Latched trip stays until unlatched
      wr(`ADDR_CTRL, 32'h2);
      time_trip(16'h0200, t);
      level <= 16'h0000;
      hold(2, 2'd1, REL + 10);
      wait_for(3, 2'd0, 2);
      wr(`ADDR_CTRL, 32'h42);
      wait_for(2, 2'd0, 6);
      // Zero delay, then squelch of small currents
      wr(`ADDR_CTRL, 32'h0);
      wr(`ADDR_DELAY, 32'd0);
      rd(`ADDR_STATUS, d);
      `CHK(d[9], 1'b1)
      `CHK(d[7:4], 4'd6)
      wr(`ADDR_CTRL, 32'h4);
      rd(`ADDR_STATUS, d);
      `CHK(d[9], 1'b0)
      wr(`ADDR_CTRL, 32'h0);
      wr(`ADDR_DELAY, 32'd30);
      wr(`ADDR_RATED, 32'd10000);
      wr(`ADDR_START_LVL, 32'd40);
      level <= 16'd45;
      hold(0, ST_IDLE, 10);
      level <= 16'd60;
      wait_for(0, ST_START, 6);
      clear_fault();
      wr(`ADDR_START_LVL, `RST_START_LVL);
      // Forcing: refused without the flag, then start and trip for the set time
      wr(`ADDR_CTRL, 32'h10);
      hold(3, 2'd0, 10);
      panel <= 1'b1;
      wr(`ADDR_CTRL, 32'h8);
      wait_for(4, 2'd1, 4);
      wr(`ADDR_CTRL, 32'h18);
      wait_for(3, 2'd1, 4);
      hold(3, 2'd1, 12);
      wait_for(3, 2'd0, 20);
      wr(`ADDR_CTRL, 32'h28);
      wait_for(2, 2'd1, 4);
      hold(2, 2'd1, 12);
      wait_for(2, 2'd0, 40);
      hold(4, 2'd1, 60);
      panel <= 1'b0;
      hold(4, 2'd1, 40);
      wait_for(4, 2'd0, 20);
      // Second reset clears the counters
      rst_n <= 1'b0;
      repeat (3) @(posedge clock);
      rst_n <= 1'b1;
      repeat (4) @(posedge clock);
      rd(`ADDR_COUNTS, d);
      `CHK(d, 32'h0)
      final_report();
   end
endmodule : protection_stage_control_test
